/* File: include/lsx_pkg.sv */
package lsx_pkg;

   localparam int LSX_DATA_W = 32;
   localparam int LSX_NUM_GLOBAL = 16;
   localparam int LSX_NUM_LOCAL = 16;
   localparam int LSX_NUM_SPECIAL = 5;
   localparam int LSX_NUM_REGS = LSX_NUM_GLOBAL + LSX_NUM_LOCAL + LSX_NUM_SPECIAL;

   // Register numbering: globals, then locals, then special-function
   localparam logic [5:0] LSX_GLOBAL_BASE = 6'h00;
   localparam logic [5:0] LSX_LOCAL_BASE = 6'h10;
   localparam logic [5:0] LSX_SPECIAL_BASE = 6'h20;
   localparam logic [5:0] LSX_REG_LIMIT = 6'h25;

   localparam int LSX_AC_OVF_FLAG_BIT = 8;
   localparam int LSX_AC_OVF_MASK_BIT = 12;
   localparam logic [31:0] LSX_AC_RESET = 32'h0000_0000;
   localparam logic [31:0] LSX_REG_RESET = 32'h0000_0000;

   localparam logic [3:0] LSX_STRB_BYTE = 4'h1;
   localparam logic [3:0] LSX_STRB_HALF = 4'h3;
   localparam logic [3:0] LSX_STRB_WORD = 4'hF;

   typedef enum logic [1:0]
   {
      LSX_SZ_BYTE = 2'h0,
      LSX_SZ_HALF = 2'h1,
      LSX_SZ_WORD = 2'h2
   } lsx_size_t;

   typedef enum logic [1:0]
   {
      LSX_CL_LOAD = 2'h0,
      LSX_CL_STORE = 2'h1,
      LSX_CL_CMP = 2'h3,
      LSX_CL_ADD = 2'h2
   } lsx_class_t;

   typedef enum logic [3:0]
   {
      LSX_OP_LD_W = 4'h0,
      LSX_OP_LD_SB = 4'h1,
      LSX_OP_LD_SH = 4'h2,
      LSX_OP_LD_UB = 4'h3,
      LSX_OP_LD_UH = 4'h4,
      LSX_OP_ST_W = 4'h5,
      LSX_OP_ST_SB = 4'h6,
      LSX_OP_ST_SH = 4'h7,
      LSX_OP_ST_UB = 4'h8,
      LSX_OP_ST_UH = 4'h9,
      LSX_OP_CMP_SB = 4'hA,
      LSX_OP_CMP_SH = 4'hB,
      LSX_OP_CMP_UB = 4'hC,
      LSX_OP_CMP_UH = 4'hD,
      LSX_OP_CMP_W = 4'hE,
      LSX_OP_ADD_W = 4'hF
   } lsx_op_t;

   function automatic logic [31:0] lsx_extend(input logic [31:0] d, input lsx_size_t sz,
                                              input logic sgn);
      logic [31:0] r;
      r = d;
      if (sz == LSX_SZ_BYTE)
      begin
         r = {{24{sgn & d[7]}}, d[7:0]};
      end
      else if (sz == LSX_SZ_HALF)
      begin
         r = {{16{sgn & d[15]}}, d[15:0]};
      end
      return r;
   endfunction : lsx_extend

   function automatic logic lsx_reg_ok(input logic [5:0] n);
      return n < LSX_REG_LIMIT;
   endfunction : lsx_reg_ok

endpackage : lsx_pkg

/* File: design/lsx_load_extend.sv */
`timescale 1ns/10ps
module lsx_load_extend
(
   input wire logic [31:0] memData,
   input wire lsx_pkg::lsx_size_t size,
   input wire logic isSigned,
   output logic [31:0] regData
);
   import lsx_pkg::*;

   // Top bit replicated for signed, zeros for unsigned, word untouched
   assign regData = lsx_extend(memData, size, isSigned);

endmodule : lsx_load_extend

/* File: design/lsx_store_narrow.sv */
`timescale 1ns/10ps
module lsx_store_narrow
(
   input wire logic [31:0] regValue,
   input wire lsx_pkg::lsx_size_t size,
   input wire logic isSigned,
   output logic [31:0] memData,
   output logic [3:0] memStrb,
   output logic overflow
);
   import lsx_pkg::*;

   logic fitsByte;
   logic fitsHalf;
   logic isByte;
   logic isHalf;

   assign isByte = (size == LSX_SZ_BYTE);
   assign isHalf = (size == LSX_SZ_HALF);

   // Discarded bits must all copy the stored sign bit
   assign fitsByte = (&regValue[31:7]) | ~(|regValue[31:7]);
   assign fitsHalf = (&regValue[31:15]) | ~(|regValue[31:15]);

   // Unsigned narrow stores never report overflow
   assign overflow = isSigned & ((isByte & ~fitsByte) | (isHalf & ~fitsHalf));

   assign memData = isByte ? {24'h000000, regValue[7:0]} :
                    isHalf ? {16'h0000, regValue[15:0]} : regValue;
   assign memStrb = isByte ? LSX_STRB_BYTE : isHalf ? LSX_STRB_HALF : LSX_STRB_WORD;

endmodule : lsx_store_narrow

/* File: design/lsx_unit.sv */
`timescale 1ns/10ps
// Behaviour
// - 16 global, 16 local, 5 special registers
// - signed and unsigned 8/16/32-bit operands; 32-bit compare and add overflow are signed only
// - two's complement, full 32-bit add
// - narrow signed only in load/store/compare
// - signed narrow load replicates top bit
// - signed narrow store truncates, flags overflow
// - overflow mask picks flag or fault
// - word load/store moves 32 bits unchanged
// - unsigned narrow load clears upper bits
// - unsigned narrow store truncates, never overflows
// - boolean results are one or zero
module lsx_unit
(
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic opValid,
   input wire lsx_pkg::lsx_op_t opCode,
   input wire logic [5:0] regA,
   input wire logic [5:0] regB,
   input wire logic [5:0] regD,
   input wire logic [31:0] memRdData,
   output logic [31:0] memWrData,
   output logic [3:0] memWrStrb,
   output logic memWrValid,
   output logic opDone,
   output logic illegalOp,
   output logic overflowFault,
   input wire logic coreWrEn,
   input wire logic [5:0] coreWrNum,
   input wire logic [31:0] coreWrData,
   input wire logic [5:0] coreRdNum,
   output logic [31:0] coreRdData,
   input wire logic acWrEn,
   input wire logic [31:0] acWrData,
   output logic [31:0] acValue
);
   import lsx_pkg::*;

   ////////////////////////////////////////////////////////////////////////////////
   // Decode

   logic [31:0] regFile_r [0:LSX_NUM_REGS-1];
   logic [31:0] acValue_r;
   logic [31:0] memWrData_r;
   logic [3:0] memWrStrb_r;
   logic memWrValid_r;
   logic opDone_r;
   logic illegalOp_r;
   logic overflowFault_r;
   logic [31:0] coreRdData_r;

   lsx_size_t opSize;
   lsx_class_t opClass;
   logic opSigned;
   logic needA;
   logic needB;
   logic needD;
   logic regsOk;
   logic opAccept;

   // Narrow sizes exist only for load, store and compare codes
   always_comb
   begin
      opSize = LSX_SZ_WORD;
      opSigned = 1'b1;
      opClass = LSX_CL_LOAD;
      unique case (opCode)
         LSX_OP_LD_W: opClass = LSX_CL_LOAD;
         LSX_OP_LD_SB: opSize = LSX_SZ_BYTE;
         LSX_OP_LD_SH: opSize = LSX_SZ_HALF;
         LSX_OP_LD_UB:
         begin
            opSize = LSX_SZ_BYTE;
            opSigned = 1'b0;
         end
         LSX_OP_LD_UH:
         begin
            opSize = LSX_SZ_HALF;
            opSigned = 1'b0;
         end
         LSX_OP_ST_W: opClass = LSX_CL_STORE;
         LSX_OP_ST_SB:
         begin
            opClass = LSX_CL_STORE;
            opSize = LSX_SZ_BYTE;
         end
         LSX_OP_ST_SH:
         begin
            opClass = LSX_CL_STORE;
            opSize = LSX_SZ_HALF;
         end
         LSX_OP_ST_UB:
         begin
            opClass = LSX_CL_STORE;
            opSize = LSX_SZ_BYTE;
            opSigned = 1'b0;
         end
         LSX_OP_ST_UH:
         begin
            opClass = LSX_CL_STORE;
            opSize = LSX_SZ_HALF;
            opSigned = 1'b0;
         end
         LSX_OP_CMP_SB:
         begin
            opClass = LSX_CL_CMP;
            opSize = LSX_SZ_BYTE;
         end
         LSX_OP_CMP_SH:
         begin
            opClass = LSX_CL_CMP;
            opSize = LSX_SZ_HALF;
         end
         LSX_OP_CMP_UB:
         begin
            opClass = LSX_CL_CMP;
            opSize = LSX_SZ_BYTE;
            opSigned = 1'b0;
         end
         LSX_OP_CMP_UH:
         begin
            opClass = LSX_CL_CMP;
            opSize = LSX_SZ_HALF;
            opSigned = 1'b0;
         end
         LSX_OP_CMP_W: opClass = LSX_CL_CMP;
         LSX_OP_ADD_W: opClass = LSX_CL_ADD;
      endcase
   end

   assign needA = (opClass != LSX_CL_LOAD);
   assign needB = (opClass == LSX_CL_CMP) || (opClass == LSX_CL_ADD);
   assign needD = (opClass != LSX_CL_STORE);
   // Numbers past the last special register are refused, not wrapped
   assign regsOk = (!needA || lsx_reg_ok(regA)) && (!needB || lsx_reg_ok(regB))
                   && (!needD || lsx_reg_ok(regD));
   assign opAccept = opValid && regsOk;

   ////////////////////////////////////////////////////////////////////////////////
   // Datapath

   logic [31:0] srcA;
   logic [31:0] srcB;
   logic [31:0] loadVal;
   logic [31:0] storeData;
   logic [3:0] storeStrb;
   logic storeOvf;
   logic [31:0] cmpA;
   logic [31:0] cmpB;
   logic cmpLess;
   logic [31:0] addSum;
   logic addOvf;
   logic [31:0] destData;
   logic destWrite;
   logic ovfEvent;
   logic ovfMask;
   logic [31:0] acNxt;

   assign srcA = lsx_reg_ok(regA) ? regFile_r[regA] : LSX_REG_RESET;
   assign srcB = lsx_reg_ok(regB) ? regFile_r[regB] : LSX_REG_RESET;

   lsx_load_extend uLoad
   (
      .memData(memRdData),
      .size(opSize),
      .isSigned(opSigned),
      .regData(loadVal)
   );

   lsx_store_narrow uStore
   (
      .regValue(srcA),
      .size(opSize),
      .isSigned(opSigned),
      .memData(storeData),
      .memStrb(storeStrb),
      .overflow(storeOvf)
   );

   // Both operands brought to 32 bits first, so one comparator serves all widths
   assign cmpA = lsx_extend(srcA, opSize, opSigned);
   assign cmpB = lsx_extend(srcB, opSize, opSigned);
   assign cmpLess = opSigned ? ($signed(cmpA) < $signed(cmpB)) : (cmpA < cmpB);

   assign addSum = srcA + srcB;
   assign addOvf = (srcA[31] == srcB[31]) && (addSum[31] != srcA[31]);

   assign destData = (opClass == LSX_CL_LOAD) ? loadVal :
                     (opClass == LSX_CL_CMP) ? {31'h00000000, cmpLess} : addSum;
   assign destWrite = opAccept && needD;

   assign ovfMask = acValue_r[LSX_AC_OVF_MASK_BIT];
   assign ovfEvent = opAccept && (((opClass == LSX_CL_STORE) && storeOvf)
                     || ((opClass == LSX_CL_ADD) && addOvf));

   // Hardware set beats a software clear in the same cycle
   always_comb
   begin
      acNxt = acWrEn ? acWrData : acValue_r;
      if (ovfEvent && ovfMask)
      begin
         acNxt[LSX_AC_OVF_FLAG_BIT] = 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // State

   // Operation write outranks a core write to the same register
   always_ff @(posedge clk_sys)
   begin
      for (int i = 0; i < LSX_NUM_REGS; i++)
      begin
         if (rst)
            regFile_r[i] <= LSX_REG_RESET;
         else if (destWrite && (regD == 6'(i)))
            regFile_r[i] <= destData;
         else if (coreWrEn && (coreWrNum == 6'(i)))
            regFile_r[i] <= coreWrData;
      end
   end

   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         acValue_r <= LSX_AC_RESET;
         memWrData_r <= LSX_REG_RESET;
         memWrStrb_r <= 4'h0;
         memWrValid_r <= 1'b0;
         opDone_r <= 1'b0;
         illegalOp_r <= 1'b0;
         overflowFault_r <= 1'b0;
         coreRdData_r <= LSX_REG_RESET;
      end
      else
      begin
         acValue_r <= acNxt;
         memWrValid_r <= opAccept && (opClass == LSX_CL_STORE);
         if (opAccept && (opClass == LSX_CL_STORE))
         begin
            memWrData_r <= storeData;
            memWrStrb_r <= storeStrb;
         end
         opDone_r <= opAccept;
         illegalOp_r <= opValid && !regsOk;
         overflowFault_r <= ovfEvent && !ovfMask;
         coreRdData_r <= lsx_reg_ok(coreRdNum) ? regFile_r[coreRdNum] : LSX_REG_RESET;
      end
   end

   assign memWrData = memWrData_r;
   assign memWrStrb = memWrStrb_r;
   assign memWrValid = memWrValid_r;
   assign opDone = opDone_r;
   assign illegalOp = illegalOp_r;
   assign overflowFault = overflowFault_r;
   assign coreRdData = coreRdData_r;
   assign acValue = acValue_r;

   ////////////////////////////////////////////////////////////////////////////////
   // Checks

   default clocking cbSys @(posedge clk_sys);
   endclocking
   default disable iff (rst);

   sequence s_ovfMasked;
      ovfEvent && ovfMask;
   endsequence

   sequence s_ovfOpen;
      ovfEvent && !ovfMask && !acWrEn;
   endsequence

   property p_signLoad;
      opAccept && (opCode == LSX_OP_LD_SB) |=>
         regFile_r[$past(regD)] == {{24{$past(memRdData[7])}}, $past(memRdData[7:0])};
   endproperty
   a_signLoad: assert property (p_signLoad) else $error("signed byte load wrong");

   property p_zeroLoad;
      opAccept && (opCode == LSX_OP_LD_UH) |=>
         regFile_r[$past(regD)] == {16'h0000, $past(memRdData[15:0])};
   endproperty
   a_zeroLoad: assert property (p_zeroLoad) else $error("unsigned half load wrong");

   property p_wordMove;
      opAccept && (opCode == LSX_OP_ST_W) |=>
         memWrValid && (memWrData == $past(srcA)) && (memWrStrb == LSX_STRB_WORD);
   endproperty
   a_wordMove: assert property (p_wordMove) else $error("word store altered data");

   property p_narrowTrunc;
      opAccept && (opCode == LSX_OP_ST_SB) |=>
         (memWrData == {24'h000000, $past(srcA[7:0])}) && (memWrStrb == LSX_STRB_BYTE);
   endproperty
   a_narrowTrunc: assert property (p_narrowTrunc) else $error("byte store not truncated");

   property p_ovfDetect;
      opAccept && (opCode == LSX_OP_ST_SH) && !ovfMask
         && !((&srcA[31:15]) || !(|srcA[31:15])) |=>
         overflowFault ##1 (overflowFault == $past(ovfEvent && !ovfMask));
   endproperty
   a_ovfDetect: assert property (p_ovfDetect) else $error("half overflow missed");

   property p_unsignedQuiet;
      opAccept && (opClass == LSX_CL_STORE) && !opSigned && !acWrEn |=>
         !overflowFault && (acValue[LSX_AC_OVF_FLAG_BIT] == $past(acValue[LSX_AC_OVF_FLAG_BIT]));
   endproperty
   a_unsignedQuiet: assert property (p_unsignedQuiet) else $error("unsigned store overflowed");

   property p_ovfFlag;
      s_ovfMasked |=> acValue[LSX_AC_OVF_FLAG_BIT] && !overflowFault;
   endproperty
   a_ovfFlag: assert property (p_ovfFlag) else $error("masked overflow not flagged");

   property p_ovfFault;
      s_ovfOpen |=> overflowFault
         && (acValue[LSX_AC_OVF_FLAG_BIT] == $past(acValue[LSX_AC_OVF_FLAG_BIT]));
   endproperty
   a_ovfFault: assert property (p_ovfFault) else $error("open overflow not faulted");

   property p_boolResult;
      opAccept && (opClass == LSX_CL_CMP) |=>
         regFile_r[$past(regD)] == {31'h00000000, $past(cmpLess)};
   endproperty
   a_boolResult: assert property (p_boolResult) else $error("compare result not 1 or 0");

   property p_addWord;
      opAccept && (opCode == LSX_OP_ADD_W) |=>
         regFile_r[$past(regD)] == $past(srcA) + $past(srcB);
   endproperty
   a_addWord: assert property (p_addWord) else $error("word add wrong");

   property p_badReg;
      opValid && !regsOk |=> illegalOp && !opDone && !memWrValid;
   endproperty
   a_badReg: assert property (p_badReg) else $error("bad register number accepted");

endmodule : lsx_unit

/* File: bench/lsx_mem_model.sv */
`timescale 1ns/10ps
module lsx_mem_model
(
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic rdEn,
   input wire logic [31:0] rdValue,
   output logic [31:0] memRdData,
   input wire logic memWrValid,
   input wire logic [31:0] memWrData,
   input wire logic [3:0] memWrStrb,
   output logic [31:0] memWord,
   output logic [15:0] storeCount
);
   logic [31:0] lastRd;
   // Released bus shows the inverse of the last value, never a stale copy
   assign memRdData = rdEn ? rdValue : ~lastRd;
   always_ff @(posedge clk_sys)
   begin
      if (rdEn)
      begin
         lastRd <= rdValue;
      end
      if (rst)
      begin
         memWord <= 32'hA5A5_A5A5;
         storeCount <= 16'h0000;
      end
      else if (memWrValid)
      begin
         storeCount <= storeCount + 16'h0001;
         for (int i = 0; i < 4; i++)
         begin
            if (memWrStrb[i])
            begin
               memWord[8*i +: 8] <= memWrData[8*i +: 8];
            end
         end
      end
   end
endmodule : lsx_mem_model

/* File: bench/lsx_unit_test.sv */
`timescale 1ns/10ps
`define CHK(got, exp) begin samplesChecked++; if ((got) !== (exp)) begin numErrors++; \
   $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp); end end
module lsx_unit_test;
   import lsx_pkg::*;
   logic clk_sys = 1'b0, rst = 1'b1, opValid = 1'b0, coreWrEn = 1'b0, acWrEn = 1'b0;
   lsx_op_t opCode = LSX_OP_LD_W;
   logic [5:0] regA = 6'h00, regB = 6'h00, regD = 6'h00, coreWrNum = 6'h00, coreRdNum = 6'h00;
   logic [31:0] coreWrData = 32'h0, acWrData = 32'h0, rdValue = 32'h0;
   logic rdEn = 1'b0;
   logic [31:0] memRdData, memWrData, coreRdData, acValue, memWord, v;
   logic [3:0] memWrStrb;
   logic memWrValid, opDone, illegalOp, overflowFault;
   logic gDone, gIll, gWv, gFlt;
   logic [15:0] storeCount;
   int numErrors = 0, samplesChecked = 0;
   always #20 clk_sys = ~clk_sys;
   lsx_unit uut (.clk_sys(clk_sys), .rst(rst), .opValid(opValid), .opCode(opCode),
      .regA(regA), .regB(regB), .regD(regD), .memRdData(memRdData), .memWrData(memWrData),
      .memWrStrb(memWrStrb), .memWrValid(memWrValid), .opDone(opDone), .illegalOp(illegalOp),
      .overflowFault(overflowFault), .coreWrEn(coreWrEn), .coreWrNum(coreWrNum),
      .coreWrData(coreWrData), .coreRdNum(coreRdNum), .coreRdData(coreRdData),
      .acWrEn(acWrEn), .acWrData(acWrData), .acValue(acValue));
   lsx_mem_model partner (.clk_sys(clk_sys), .rst(rst), .rdEn(rdEn), .rdValue(rdValue),
      .memRdData(memRdData), .memWrValid(memWrValid), .memWrData(memWrData),
      .memWrStrb(memWrStrb), .memWord(memWord), .storeCount(storeCount));
   ////////////////////////////////////////////////////////////////////////////////
   task automatic summarize();
      $display("checks=%0d errors=%0d", samplesChecked, numErrors);
      if (numErrors == 0 && samplesChecked > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : summarize
   // One op; pulses are caught at the falling edge after the taking edge
   task automatic doOp(input lsx_op_t c, input logic [5:0] a, b, d, input logic [31:0] m);
      opCode = c;
      regA = a;
      regB = b;
      regD = d;
      rdEn = 1'b1;
      rdValue = m;
      opValid = 1'b1;
      @(posedge clk_sys);
      @(negedge clk_sys);
      opValid = 1'b0;
      rdEn = 1'b0;
      gDone = opDone;
      gIll = illegalOp;
      gWv = memWrValid;
      gFlt = overflowFault;
   endtask : doOp
   task automatic wrReg(input logic [5:0] n, input logic [31:0] d);
      coreWrEn = 1'b1;
      coreWrNum = n;
      coreWrData = d;
      @(posedge clk_sys);
      @(negedge clk_sys);
      coreWrEn = 1'b0;
   endtask : wrReg
   task automatic rdReg(input logic [5:0] n, output logic [31:0] d);
      coreRdNum = n;
      @(posedge clk_sys);
      @(negedge clk_sys);
      d = coreRdData;
   endtask : rdReg
   task automatic setAc(input logic [31:0] d);
      acWrEn = 1'b1;
      acWrData = d;
      @(posedge clk_sys);
      @(negedge clk_sys);
      acWrEn = 1'b0;
   endtask : setAc
   ////////////////////////////////////////////////////////////////////////////////
   task automatic testRegs();
      logic [5:0] nums [7] = '{6'h00, 6'h0F, 6'h10, 6'h1F, 6'h20, 6'h24, 6'h25};
      for (int i = 0; i < 7; i++)
      begin
         wrReg(nums[i], 32'hC0DE_0000 | 32'(i));
         rdReg(nums[i], v);
         `CHK(v, (i < 6) ? (32'hC0DE_0000 | 32'(i)) : 32'h0000_0000)
      end
   endtask : testRegs
   task automatic testLoads();
      lsx_op_t ops [8] = '{LSX_OP_LD_SB, LSX_OP_LD_SB, LSX_OP_LD_SB, LSX_OP_LD_SH,
         LSX_OP_LD_SH, LSX_OP_LD_UB, LSX_OP_LD_UH, LSX_OP_LD_W};
      logic [31:0] mem [8] = '{32'h7A, 32'hFA, 32'h1234_56FA, 32'h05A5, 32'h85A5,
         32'hFFFF_FFFA, 32'hABCD_85A5, 32'h8765_4321};
      logic [31:0] exp [8] = '{32'h7A, 32'hFFFF_FFFA, 32'hFFFF_FFFA, 32'h05A5,
         32'hFFFF_85A5, 32'hFA, 32'h85A5, 32'h8765_4321};
      for (int i = 0; i < 8; i++)
      begin
         doOp(ops[i], 6'h00, 6'h00, 6'h1F, mem[i]);
         `CHK({gDone, gWv, gFlt}, 3'b100)
         rdReg(6'h1F, v);
         `CHK(v, exp[i])
      end
   endtask : testLoads
   task automatic testStores();
      lsx_op_t ops [8] = '{LSX_OP_ST_SB, LSX_OP_ST_SB, LSX_OP_ST_SB, LSX_OP_ST_SH,
         LSX_OP_ST_SH, LSX_OP_ST_UB, LSX_OP_ST_UH, LSX_OP_ST_W};
      logic [31:0] src [8] = '{32'h180, 32'hFFFF_FF80, 32'h7F, 32'h8000, 32'hFFFF_8000,
         32'h180, 32'h1234_5678, 32'h8000_0001};
      logic [31:0] dat [8] = '{32'h80, 32'h80, 32'h7F, 32'h8000, 32'h8000, 32'h80,
         32'h5678, 32'h8000_0001};
      logic [3:0] stb [8] = '{LSX_STRB_BYTE, LSX_STRB_BYTE, LSX_STRB_BYTE, LSX_STRB_HALF,
         LSX_STRB_HALF, LSX_STRB_BYTE, LSX_STRB_HALF, LSX_STRB_WORD};
      logic ovf [8] = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0};
      for (int i = 0; i < 8; i++)
      begin
         wrReg(6'h05, src[i]);
         doOp(ops[i], 6'h05, 6'h00, 6'h00, 32'h0);
         `CHK({gDone, gWv, memWrStrb, memWrData}, {2'b11, stb[i], dat[i]})
         `CHK(gFlt, ovf[i])
         `CHK(acValue, 32'h0000_0000)
      end
      @(negedge clk_sys);
      `CHK(memWord, 32'h8000_0001)
   endtask : testStores
   task automatic testMask();
      setAc(32'h0000_1000);
      wrReg(6'h05, 32'h0000_0180);
      doOp(LSX_OP_ST_SB, 6'h05, 6'h00, 6'h00, 32'h0);
      @(negedge clk_sys);
      `CHK({gWv, gFlt, acValue}, {2'b10, 32'h0000_1100})
      // Flag clear written in the overflow cycle must lose to the set
      acWrEn = 1'b1;
      acWrData = 32'h0000_1000;
      doOp(LSX_OP_ST_SB, 6'h05, 6'h00, 6'h00, 32'h0);
      `CHK({gFlt, acValue}, {1'b0, 32'h0000_1100})
      setAc(32'h0000_0000);
      doOp(LSX_OP_ST_SB, 6'h05, 6'h00, 6'h00, 32'h0);
      `CHK({gFlt, acValue}, {1'b1, 32'h0000_0000})
   endtask : testMask
   task automatic testCmpAdd();
      lsx_op_t ops [5] = '{LSX_OP_CMP_SB, LSX_OP_CMP_SH, LSX_OP_CMP_UB, LSX_OP_CMP_UH,
         LSX_OP_CMP_W};
      logic [31:0] exp [5] = '{32'h1, 32'h0, 32'h0, 32'h0, 32'h0};
      wrReg(6'h10, 32'h0000_00FF);
      @(negedge clk_sys);
      wrReg(6'h11, 32'h0000_0001);
      for (int i = 0; i < 5; i++)
      begin
         doOp(ops[i], 6'h10, 6'h11, 6'h12, 32'h0);
         rdReg(6'h12, v);
         `CHK(v, exp[i])
      end
      doOp(LSX_OP_CMP_W, 6'h11, 6'h10, 6'h12, 32'h0);
      rdReg(6'h12, v);
      `CHK(v, 32'h0000_0001)
      wrReg(6'h10, 32'h7FFF_FFFF);
      doOp(LSX_OP_ADD_W, 6'h10, 6'h11, 6'h13, 32'h0);
      `CHK({gDone, gFlt}, 2'b11)
      rdReg(6'h13, v);
      `CHK(v, 32'h8000_0000)
   endtask : testCmpAdd
   task automatic testIllegal();
      doOp(LSX_OP_LD_W, 6'h00, 6'h00, 6'h25, 32'h1111_2222);
      `CHK({gDone, gIll}, 2'b01)
      wrReg(6'h05, 32'h0000_0180);
      doOp(LSX_OP_ST_SB, 6'h25, 6'h00, 6'h00, 32'h0);
      `CHK({gIll, gWv, gFlt}, 3'b100)
      // Eight stores in testStores, three in testMask, none refused ones
      `CHK(storeCount, 16'h000B)
   endtask : testIllegal
   ////////////////////////////////////////////////////////////////////////////////
   initial
   begin
      repeat (4) @(negedge clk_sys);
      rst = 1'b0;
      `CHK({acValue, coreRdData}, 64'h0)
      testRegs();
      testLoads();
      testStores();
      testMask();
      testCmpAdd();
      testIllegal();
      summarize();
   end
   initial
   begin
      repeat (5000) @(posedge clk_sys);
      numErrors++;
      summarize();
   end
endmodule : lsx_unit_test
